// [design/pse_control_pin_logic.v]
// control and status pin logic of the port power controller
// Functional notes
// [RQ1] over-supply rising edge sheds low-priority ports
// [RQ2] reset low holds microcontroller disabled
// [RQ3] reset restores defaults, turns ports off
// [RQ4] host holds reset low over 10 us
// [RQ5] any port fault pulls alert low
// [RQ6] alert changes only between bus commands
// [RQ7] alert is open drain, low only
// [RQ8] straps latched at release; address 0100+straps
// [RQ9] over-supply synchronised, one edge one event
`timescale 1ns/10ps
`default_nettype none
`include "pin_ctl_map.vh"
module pse_control_pin_logic (
	input  wire       core_clk,
	input  wire       reset_n,
	input  wire       over_supply_shed_in,
	input  wire [2:0] bus_address_straps,
	input  wire [3:0] port_fault,
	input  wire       bus_cmd_busy,
	input  wire       prio_wr,
	input  wire [3:0] prio_wdata,
	input  wire [3:0] port_on_req,
	input  wire [3:0] port_off_req,
	output reg  [3:0] port_enable_r,
	output reg  [3:0] port_prio_r,
	output reg        mcu_enable_r,
	output reg  [6:0] slave_addr_r,
	output reg        shed_event_r,
	output wire       fault_alert_low_o,
	output wire       fault_alert_low_oe_n
);
	wire       oss_level;
	reg        oss_prev_r;
	reg        straps_taken_r;
	reg  [2:0] settle_r;
	reg        alert_r;
	wire [2:0] straps_lvl;
	wire       oss_rise;

	// over-supply pin crosses in through three stages [RQ9]
	pin_sync3 u_oss (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.rst_val  (1'b1),
		.pin_in   (over_supply_shed_in),
		.level_r  (oss_level)
	);

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_strap
			pin_sync3 u_strap (
				.core_clk (core_clk),
				.reset_n  (reset_n),
				.rst_val  (1'b1),
				.pin_in   (bus_address_straps[g]),
				.level_r  (straps_lvl[g])
			);
		end
	endgenerate

	// two consecutive synchronised samples give a single edge event [RQ9]
	assign oss_rise = oss_level & ~oss_prev_r;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			oss_prev_r   <= 1'b1;
			shed_event_r <= 1'b0;
		end else begin
			oss_prev_r   <= oss_level;
			shed_event_r <= oss_rise; // [RQ9]
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mcu_enable_r <= 1'b0; // [RQ2]
		end else begin
			mcu_enable_r <= 1'b1;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			port_prio_r <= `PRIO_RESET; // [RQ3]
		end else if (prio_wr) begin
			port_prio_r <= prio_wdata;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			port_enable_r <= 4'h0; // [RQ3]
		end else begin
			// shedding wins over a turn-on in the same cycle [RQ1]
			port_enable_r <= (port_enable_r | port_on_req) & ~port_off_req
				& ~(oss_rise ? port_prio_r : 4'h0); // [RQ1]
		end
	end

	// strap synchronisers need several edges after release before their levels are valid
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			settle_r <= 3'h0;
		end else if (settle_r != `STRAP_SETTLE) begin
			settle_r <= settle_r + 3'h1;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			slave_addr_r   <= {`ADDR_HIGH_BITS, 3'h7};
			straps_taken_r <= 1'b0;
		end else if (!straps_taken_r && (settle_r == `STRAP_SETTLE)) begin
			straps_taken_r <= 1'b1;
			slave_addr_r   <= {`ADDR_HIGH_BITS, straps_lvl}; // [RQ8]
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			alert_r <= 1'b0;
		end else if (!bus_cmd_busy) begin
			// alert only moves while no command is in flight [RQ6]
			alert_r <= |port_fault; // [RQ5]
		end
	end

	// pin only ever driven low; high comes from the pull-up [RQ7]
	assign fault_alert_low_o    = 1'b0;
	assign fault_alert_low_oe_n = ~alert_r; // [RQ7]
endmodule // pse_control_pin_logic
`default_nettype wire

// [design/pin_ctl_map.vh]
// constants for the control and status pin logic
`ifndef PIN_CTL_MAP_VH
`define PIN_CTL_MAP_VH
`define PORT_COUNT        4
`define PRIO_REG_OFFSET   8'h15
`define PRIO_RESET        4'h0
`define ADDR_HIGH_BITS    4'h4
`define RESET_MIN_NS      10000
`define CLK_PERIOD_NS     5
`define RESET_MIN_CYCLES  ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE      3'h5
`endif

// [design/pin_sync3.v]
// three-stage synchroniser; output changes when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 (
	input  wire core_clk,
	input  wire reset_n,
	input  wire rst_val,
	input  wire pin_in,
	output reg  level_r
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_r    <= 1'b1;
			s2_r    <= 1'b1;
			s3_r    <= 1'b1;
			level_r <= 1'b1;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end
	// rst_val unused beyond documenting the pulled-up idle level
	wire unused_ok = rst_val;
endmodule // pin_sync3
`default_nettype wire

// [verification/pin_mon_monitor.sv]
// port checker
`timescale 1ns/10ps
`default_nettype none
module pin_mon(input wire logic core_clk,reset_n,over_supply_shed_in,bus_cmd_busy,shed_event_r,
fault_alert_low_o,fault_alert_low_oe_n,input wire logic[3:0]port_fault,port_enable_r,port_prio_r);
default clocking@(posedge core_clk);endclocking
default disable iff(!reset_n);
sequence up;!over_supply_shed_in##1 over_supply_shed_in;endsequence
chk_mask_off:assert property(shed_event_r|->!(port_enable_r&port_prio_r))else $error("mask");
chk_shed_rise:assert property(up|->##[1:9]shed_event_r)else $error("rise");
chk_alert_set:
assert property(!bus_cmd_busy|=>fault_alert_low_oe_n==($past(port_fault)==0))else $error("alert");
chk_alert_hold:
assert property(bus_cmd_busy|=>$stable(fault_alert_low_oe_n))else $error("hold");
chk_drain_only:assert property(!fault_alert_low_o)else $error("drive");
chk_shed_single:assert property(shed_event_r|=>!shed_event_r)else $error("double");
endmodule//pin_mon
bind pse_control_pin_logic pin_mon i_mon(.*);
`default_nettype wire

// [verification/host_model.sv]
// host bus activity
`timescale 1ns/10ps
`default_nettype none
module host_model(input wire logic core_clk,cmd,output logic busy=0);
always@(posedge core_clk)if(cmd)busy<=~busy;//a command opens or closes activity
endmodule//host_model
`default_nettype wire

// [verification/tb_pse_control_pin_logic.sv]
// pin logic bench
`timescale 1ns/10ps
`default_nettype none
module tb_pse_control_pin_logic;
logic core_clk=0,reset_n=0,over_supply_shed_in=1,prio_wr=0,cmd=0;
logic[2:0]bus_address_straps=2;
logic[3:0]port_fault=0,prio_wdata=5,port_on_req=0,port_off_req=0;
wire logic[3:0]port_enable_r,port_prio_r;
wire logic[6:0]slave_addr_r;
wire logic mcu_enable_r,shed_event_r,fault_alert_low_o,fault_alert_low_oe_n,bus_cmd_busy;
int failures=0,checks=0,n=0,sheds=0;
always@(posedge core_clk)if(shed_event_r===1'b1)sheds++;
pse_control_pin_logic i_dut(.*);
host_model i_host(.core_clk,.cmd,.busy(bus_cmd_busy));
initial forever#2.5 core_clk=~core_clk;
always@(posedge core_clk)if(++n>3000)begin failures++;print_verdict;end
task w(int k);repeat(k)@(negedge core_clk);endtask
task cmp(input[7:0]g,e);checks++;
if(g!==e)begin failures++;$display("[FAIL] %0t %h %h",$time,g,e);end endtask
task print_verdict;$display("%0d %0d",checks,failures);
if(failures==0&&checks>0)$display("Finished cleanly");
else $display("Finished with errors");
$finish;endtask
task shed;prio_wr=1;port_on_req=15;w(1);prio_wr=0;port_on_req=0;over_supply_shed_in=0;w(6);
over_supply_shed_in=1;w(12);cmp(port_enable_r,4'ha);
cmp(port_prio_r,4'h5);
cmp(sheds,1);
cmp(fault_alert_low_o,0);endtask
task alert;cmd=1;w(1);cmd=0;port_fault=2;w(4);cmp(fault_alert_low_oe_n,1);
cmd=1;w(1);cmd=0;w(2);cmp(fault_alert_low_oe_n,0);endtask
task rst;reset_n=0;w(2001);cmp(port_enable_r,0);
cmp(fault_alert_low_oe_n,1);
cmp(mcu_enable_r,0);reset_n=1;w(8);cmp(slave_addr_r,8'h22);
cmp(mcu_enable_r,1);endtask
initial begin w(20);reset_n=1;w(8);shed;alert;rst;print_verdict;end
endmodule//tb_pse_control_pin_logic
`default_nettype wire
